//--- rtl/urd_pkg.sv
package urd_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned RST_PW_US = 100;
    localparam int unsigned READY_US = 500;
    localparam int unsigned CHIRP_MIN_US = 18;
    localparam int unsigned CHIRP_MAX_US = 128;
    // cycles per microsecond first, so no product overflows 32 bits
    localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;
    localparam int unsigned RST_PW_CYC = RST_PW_US * CYC_PER_US;
    localparam int unsigned READY_CYC = READY_US * CYC_PER_US;
    localparam int unsigned CHIRP_MIN_CYC = CHIRP_MIN_US * CYC_PER_US;
    localparam int unsigned CHIRP_MAX_CYC = CHIRP_MAX_US * CYC_PER_US;
    localparam int unsigned CNT_W = 16;

    // ----------------------------------------------------------------
    // strap values
    // ----------------------------------------------------------------
    localparam logic [1:0] BOOST_DEFAULT = 2'h3;
    localparam logic [6:0] I2C_ADDR = 7'h2c;

    typedef enum logic [1:0] {
        URD_EQ_LOW,
        URD_EQ_MED,
        URD_EQ_HIGH
    } urd_eq_e;

    typedef enum {
        URD_ST_OFF,
        URD_ST_READY,
        URD_ST_RUN
    } urd_st_e;

    typedef enum {
        URD_HS_IDLE,
        URD_HS_FIXTURE,
        URD_HS_CHIRP_J,
        URD_HS_CHIRP_K,
        URD_HS_WAIT_SQ,
        URD_HS_ACTIVE
    } urd_hs_e;

    // three-level strap pin as seen by the pad: driven or floating
    typedef struct packed {
        logic level;
        logic floating;
    } urd_tri_s;

    // compensation settings handed to the analog path
    typedef struct packed {
        logic [1:0] edge_boost;
        logic [1:0] dc_boost;
        logic [1:0] eq_level;
        logic comp_en;
    } urd_comp_s;

    // line events reported by the analog detectors
    typedef struct packed {
        logic pullup_seen;
        logic disconnect;
        logic low_speed;
        logic bus_reset;
        logic chirp_j;
        logic chirp_k;
        logic squelch;
        logic test_fixture;
        logic test_packet;
    } urd_line_s;

endpackage : urd_pkg

//--- rtl/urd_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// (R01) boost strap latched once, floating means three; code has no floating detect on boost_strap
// (R02) pin mode ties boosts; serial mode separate
// (R03) charger always on; low dedicated, high downstream
// (R04) equaliser pin read as three levels
// (R05) equaliser pin then outputs high-speed flag
// (R06) fixture then test packet raises hs flag
// (R07) valid chirp pair then squelch raises flag
// (R08) unused shared pins carry nothing
// (R09) serial target answers at fixed address
// (R10) serial mode only when both lines high
// (R11) reset input low holds reset and shutdown
// (R12) controller holds reset until supply settles
// (R13) attach flag rises on data-line pull-up
// (R14) attach flag clears on disconnect
// (R15) low speed: no compensation, attach high
// (R16) reset valid after hundred microseconds low
// (R17) operational within five hundred microseconds
// (R18) straps latched at release, then outputs enabled
module urd_ctrl #(
    parameter int unsigned RST_PW_CYCLES = urd_pkg::RST_PW_CYC,
    parameter int unsigned READY_CYCLES = urd_pkg::READY_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reset_shutdown_n,
    input wire logic [1:0] boost_strap,
    input wire urd_pkg::urd_tri_s rx_equaliser_strap,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic charge_port_select,
    input wire urd_pkg::urd_line_s line,
    input wire logic [1:0] i2c_edge_boost,
    input wire logic [1:0] i2c_dc_boost,
    input wire logic i2c_boost_we,
    input wire logic [6:0] i2c_rx_addr,
    input wire logic i2c_addr_valid,
    output logic i2c_mode,
    output logic i2c_addr_match,
    output logic shutdown,
    output logic device_ready,
    output logic charger_en,
    output logic dedicated_charge_behaviour,
    output logic downstream_charge_behaviour,
    output urd_pkg::urd_comp_s comp,
    output logic hs_active_flag,
    output logic eq_pin_oe,
    output logic attach_flag,
    output logic scl_pin_oe
);

    // ----------------------------------------------------------------
    // reset pin qualification
    // ----------------------------------------------------------------
    logic [urd_pkg::CNT_W-1:0] low_cnt_reg;
    logic held_reg;
    logic latched_reg;
    urd_pkg::urd_st_e st_reg;
    logic [urd_pkg::CNT_W-1:0] rdy_cnt_reg;

    // (R16) low width filter
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_reg <= '0;
            held_reg <= 1'b1;
        end else if (reset_shutdown_n) begin
            low_cnt_reg <= '0;
            held_reg <= 1'b0;
        end else if (low_cnt_reg >= urd_pkg::CNT_W'(RST_PW_CYCLES - 1)) begin
            held_reg <= 1'b1;
        end else begin
            low_cnt_reg <= low_cnt_reg + 1'b1;
        end
    end

    // (R11) shutdown and startup
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= urd_pkg::URD_ST_OFF;
            rdy_cnt_reg <= '0;
            shutdown <= 1'b1;
            device_ready <= 1'b0;
        end else begin
            case (st_reg)
                urd_pkg::URD_ST_OFF: begin
                    shutdown <= 1'b1;
                    device_ready <= 1'b0;
                    rdy_cnt_reg <= '0;
                    if (!held_reg) begin
                        st_reg <= urd_pkg::URD_ST_READY;
                        shutdown <= 1'b0;
                    end
                end
                urd_pkg::URD_ST_READY: begin
                    // (R17) bounded start time
                    rdy_cnt_reg <= rdy_cnt_reg + 1'b1;
                    if (held_reg) begin
                        st_reg <= urd_pkg::URD_ST_OFF;
                        shutdown <= 1'b1;
                    end else if (rdy_cnt_reg >=
                                 urd_pkg::CNT_W'(READY_CYCLES - 2)) begin
                        st_reg <= urd_pkg::URD_ST_RUN;
                        device_ready <= 1'b1;
                    end
                end
                urd_pkg::URD_ST_RUN: begin
                    if (held_reg) begin
                        st_reg <= urd_pkg::URD_ST_OFF;
                        shutdown <= 1'b1;
                        device_ready <= 1'b0;
                    end
                end
                default: st_reg <= urd_pkg::URD_ST_OFF;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // strap capture
    // ----------------------------------------------------------------
    logic [1:0] boost_lat_reg;
    logic [1:0] eq_lat_reg;

    // (R18) capture at release
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            latched_reg <= 1'b0;
            boost_lat_reg <= urd_pkg::BOOST_DEFAULT;
            eq_lat_reg <= 2'(urd_pkg::URD_EQ_MED);
            i2c_mode <= 1'b0;
        end else if (held_reg) begin
            latched_reg <= 1'b0;
        end else if (!latched_reg) begin
            latched_reg <= 1'b1;
            // (R01) captured once, boost_strap taken as read with no floating detect
            boost_lat_reg <= boost_strap;
            // (R10) both lines high
            i2c_mode <= scl_in & sda_in;
            // (R04) three-level equaliser read
            if (rx_equaliser_strap.floating) begin
                eq_lat_reg <= 2'(urd_pkg::URD_EQ_MED);
            end else if (rx_equaliser_strap.level) begin
                eq_lat_reg <= 2'(urd_pkg::URD_EQ_HIGH);
            end else begin
                eq_lat_reg <= 2'(urd_pkg::URD_EQ_LOW);
            end
        end
    end

    // ----------------------------------------------------------------
    // boost and compensation
    // ----------------------------------------------------------------
    logic [1:0] edge_reg;
    logic [1:0] dc_reg;
    logic ls_reg;

    // (R02) separate boosts over serial
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_reg <= urd_pkg::BOOST_DEFAULT;
            dc_reg <= urd_pkg::BOOST_DEFAULT;
        end else if (!latched_reg) begin
            edge_reg <= boost_strap;
            dc_reg <= boost_strap;
        end else if (!i2c_mode) begin
            edge_reg <= boost_lat_reg;
            dc_reg <= boost_lat_reg;
        end else if (i2c_boost_we) begin
            edge_reg <= i2c_edge_boost;
            dc_reg <= i2c_dc_boost;
        end
    end

    // (R15) low speed tracking
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ls_reg <= 1'b0;
        end else if (held_reg || line.disconnect) begin
            ls_reg <= 1'b0;
        end else if (line.low_speed) begin
            ls_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            comp <= '0;
        end else begin
            comp.edge_boost <= edge_reg;
            comp.dc_boost <= dc_reg;
            comp.eq_level <= eq_lat_reg;
            // (R15) compensation off at low speed
            comp.comp_en <= device_ready & ~ls_reg & ~line.low_speed;
        end
    end

    // (R03) charger always enabled
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            charger_en <= 1'b0;
            dedicated_charge_behaviour <= 1'b0;
            downstream_charge_behaviour <= 1'b0;
        end else begin
            charger_en <= 1'b1;
            dedicated_charge_behaviour <= ~charge_port_select;
            downstream_charge_behaviour <= charge_port_select;
        end
    end

    // ----------------------------------------------------------------
    // attach flag
    // ----------------------------------------------------------------
    logic attach_reg;

    // (R13) rise on pull-up; (R14) clear on disconnect wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            attach_reg <= 1'b0;
        end else if (held_reg || line.disconnect) begin
            attach_reg <= 1'b0;
        end else if (line.pullup_seen || line.low_speed) begin
            attach_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // high-speed detection
    // ----------------------------------------------------------------
    urd_pkg::urd_hs_e hs_reg;
    logic [urd_pkg::CNT_W-1:0] chirp_cnt_reg;

    function automatic logic chirp_ok(input logic [urd_pkg::CNT_W-1:0] n);
        chirp_ok = (n >= urd_pkg::CNT_W'(urd_pkg::CHIRP_MIN_CYC)) &&
                   (n <= urd_pkg::CNT_W'(urd_pkg::CHIRP_MAX_CYC));
    endfunction : chirp_ok

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_reg <= urd_pkg::URD_HS_IDLE;
            chirp_cnt_reg <= '0;
        end else if (held_reg || line.disconnect || ls_reg) begin
            hs_reg <= urd_pkg::URD_HS_IDLE;
            chirp_cnt_reg <= '0;
        end else begin
            case (hs_reg)
                urd_pkg::URD_HS_IDLE: begin
                    // the cycle that opens chirp j counts as its first
                    chirp_cnt_reg <= 16'h0001;
                    // (R06) fixture from unconnected
                    if (line.test_fixture && !attach_reg) begin
                        hs_reg <= urd_pkg::URD_HS_FIXTURE;
                    end else if (line.bus_reset && line.chirp_j) begin
                        hs_reg <= urd_pkg::URD_HS_CHIRP_J;
                    end
                end
                urd_pkg::URD_HS_FIXTURE: begin
                    if (line.test_packet) begin
                        hs_reg <= urd_pkg::URD_HS_ACTIVE;
                    end
                end
                // (R07) chirp widths in window
                urd_pkg::URD_HS_CHIRP_J: begin
                    if (line.chirp_j) begin
                        chirp_cnt_reg <= chirp_cnt_reg + 1'b1;
                    end else if (line.chirp_k && chirp_ok(chirp_cnt_reg)) begin
                        chirp_cnt_reg <= 16'h0001;
                        hs_reg <= urd_pkg::URD_HS_CHIRP_K;
                    end else begin
                        hs_reg <= urd_pkg::URD_HS_IDLE;
                    end
                end
                urd_pkg::URD_HS_CHIRP_K: begin
                    if (line.chirp_k) begin
                        chirp_cnt_reg <= chirp_cnt_reg + 1'b1;
                    end else if (chirp_ok(chirp_cnt_reg)) begin
                        hs_reg <= urd_pkg::URD_HS_WAIT_SQ;
                    end else begin
                        hs_reg <= urd_pkg::URD_HS_IDLE;
                    end
                end
                urd_pkg::URD_HS_WAIT_SQ: begin
                    if (line.squelch) begin
                        hs_reg <= urd_pkg::URD_HS_ACTIVE;
                    end
                end
                urd_pkg::URD_HS_ACTIVE: begin
                    if (line.bus_reset && line.chirp_j) begin
                        hs_reg <= urd_pkg::URD_HS_CHIRP_J;
                        chirp_cnt_reg <= 16'h0001;
                    end
                end
                default: hs_reg <= urd_pkg::URD_HS_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // shared pin outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_active_flag <= 1'b0;
            eq_pin_oe <= 1'b0;
            attach_flag <= 1'b0;
            scl_pin_oe <= 1'b0;
        end else begin
            // (R05) flag after strap latch; (R08) silent in serial mode
            eq_pin_oe <= latched_reg & ~held_reg & ~i2c_mode;
            hs_active_flag <= latched_reg & ~held_reg & ~i2c_mode &
                              ~ls_reg & (hs_reg == urd_pkg::URD_HS_ACTIVE);
            // (R13) attach on clock pin in pin mode
            scl_pin_oe <= latched_reg & ~held_reg & ~i2c_mode;
            attach_flag <= latched_reg & ~held_reg & ~i2c_mode & attach_reg;
        end
    end

    // (R09) fixed target address
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            i2c_addr_match <= 1'b0;
        end else begin
            i2c_addr_match <= i2c_mode & i2c_addr_valid & ~held_reg &
                              (i2c_rx_addr == urd_pkg::I2C_ADDR);
        end
    end

endmodule : urd_ctrl

//--- verif/urd_ctrl_asserts.sv
`timescale 1ns/1ps
module urd_ctrl_asserts #(
    parameter int unsigned RST_PW_CYCLES = 8,
    parameter int unsigned READY_CYCLES = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reset_shutdown_n,
    input wire logic charge_port_select,
    input wire urd_pkg::urd_line_s line,
    input wire logic [6:0] i2c_rx_addr,
    input wire logic i2c_addr_valid,
    input wire logic i2c_mode,
    input wire logic i2c_addr_match,
    input wire logic shutdown,
    input wire logic device_ready,
    input wire logic charger_en,
    input wire logic dedicated_charge_behaviour,
    input wire logic downstream_charge_behaviour,
    input wire urd_pkg::urd_comp_s comp,
    input wire logic hs_active_flag,
    input wire logic eq_pin_oe,
    input wire logic attach_flag,
    input wire logic scl_pin_oe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // ----------------
    // pin level counters
    // ----------------
    int unsigned low_cnt;
    int unsigned up_cnt;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= 0;
        end else if (reset_shutdown_n) begin
            low_cnt <= 0;
        end else if (low_cnt < 1000) begin
            low_cnt <= low_cnt + 1;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_cnt <= 0;
        end else if (!reset_shutdown_n) begin
            up_cnt <= 0;
        end else if (up_cnt < 1000) begin
            up_cnt <= up_cnt + 1;
        end
    end
    // ----------------
    // properties
    // ----------------
    a_addr_hit: assert property (
        i2c_addr_valid && i2c_mode && i2c_rx_addr == 7'h2c
        |=> i2c_addr_match) else $error("address match missing");
    a_addr_own: assert property (
        i2c_addr_match |-> $past(i2c_addr_valid) && $past(i2c_mode)
        && $past(i2c_rx_addr) == 7'h2c) else $error("stray match");
    a_charge_follow: assert property (
        charger_en && $past(charger_en) |-> dedicated_charge_behaviour
        == !$past(charge_port_select) && downstream_charge_behaviour
        == $past(charge_port_select)) else $error("charge mode wrong");
    a_charger_on: assert property (
        $past(rst_n, 2) |-> charger_en) else $error("charger off");
    a_serial_quiet: assert property (
        i2c_mode |-> !eq_pin_oe && !scl_pin_oe)
        else $error("shared pin driven in serial mode");
    a_hs_pin: assert property (
        hs_active_flag |-> eq_pin_oe) else $error("flag pin not driven");
    a_boost_tied: assert property (
        eq_pin_oe && !i2c_mode |-> comp.edge_boost == comp.dc_boost)
        else $error("boosts differ in pin mode");
    a_boost_held: assert property (
        eq_pin_oe && $past(eq_pin_oe) && !i2c_mode
        |-> $stable(comp.edge_boost) && $stable(comp.dc_boost))
        else $error("boost changed after latch");
    a_disc_clear: assert property (
        line.disconnect |-> ##2 (!attach_flag && !hs_active_flag))
        else $error("flags kept after disconnect");
    a_ls_no_hs: assert property (
        line.low_speed && !hs_active_flag |=> !hs_active_flag)
        else $error("hs flag in low speed");
    a_pulse_short: assert property (
        $rose(shutdown) |-> low_cnt + 2 >= RST_PW_CYCLES)
        else $error("short low pulse accepted");
    a_pulse_long: assert property (
        low_cnt == RST_PW_CYCLES + 3 |-> shutdown)
        else $error("long low pulse ignored");
    a_ready_bound: assert property (
        up_cnt == READY_CYCLES + 4 |-> device_ready)
        else $error("not ready in time");
    c_hs: cover property ($rose(hs_active_flag));
    c_attach: cover property ($rose(attach_flag));
    c_match: cover property (i2c_addr_match);
    c_shut: cover property ($rose(shutdown));
endmodule : urd_ctrl_asserts

bind urd_ctrl urd_ctrl_asserts #(
    .RST_PW_CYCLES(RST_PW_CYCLES),
    .READY_CYCLES(READY_CYCLES)
) u_chk (
    .sys_clk, .rst_n, .reset_shutdown_n, .charge_port_select, .line,
    .i2c_rx_addr, .i2c_addr_valid, .i2c_mode, .i2c_addr_match,
    .shutdown, .device_ready, .charger_en, .dedicated_charge_behaviour,
    .downstream_charge_behaviour, .comp, .hs_active_flag, .eq_pin_oe,
    .attach_flag, .scl_pin_oe
);

//--- verif/urd_line_peer.sv
`timescale 1ns/1ps
module urd_line_peer (
    input wire logic sys_clk,
    input wire urd_pkg::urd_line_s ev,
    output urd_pkg::urd_line_s line
);
    urd_pkg::urd_line_s seq = '0;
    assign line = ev | seq;
    task automatic chirp(input int jc, input int kc);
        @(posedge sys_clk);
        seq.bus_reset <= 1'b1;
        seq.chirp_j <= 1'b1;
        @(posedge sys_clk);
        seq.bus_reset <= 1'b0;
        repeat (jc - 1) @(posedge sys_clk);
        seq.chirp_j <= 1'b0;
        seq.chirp_k <= 1'b1;
        repeat (kc) @(posedge sys_clk);
        seq.chirp_k <= 1'b0;
        seq.squelch <= 1'b1;
        repeat (2) @(posedge sys_clk);
        seq.squelch <= 1'b0;
    endtask : chirp
    task automatic fixture();
        @(posedge sys_clk);
        seq.test_fixture <= 1'b1;
        repeat (4) @(posedge sys_clk);
        seq.test_fixture <= 1'b0;
        seq.test_packet <= 1'b1;
        repeat (4) @(posedge sys_clk);
        seq.test_packet <= 1'b0;
    endtask : fixture
endmodule : urd_line_peer

//--- verif/urd_ctrl_tb.sv
`timescale 1ns/1ps
module urd_ctrl_tb;
    localparam int unsigned PW = 8;
    localparam int unsigned RDY = 16;
    localparam int MN = urd_pkg::CHIRP_MIN_CYC;
    localparam int MX = urd_pkg::CHIRP_MAX_CYC;
    localparam int JC [3] = '{MN - 20, MN + 80, MX};
    localparam int KC [3] = '{MN + 80, MX + 80, MN};
    localparam urd_pkg::urd_line_s PULL = 9'h100;
    localparam urd_pkg::urd_line_s DISC = 9'h080;
    localparam urd_pkg::urd_line_s LS = 9'h040;
    localparam urd_pkg::urd_eq_e EQX [3] = '{urd_pkg::URD_EQ_LOW,
        urd_pkg::URD_EQ_MED, urd_pkg::URD_EQ_HIGH};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pin_n = 1'b0;
    logic [1:0] boost = 2'h0;
    urd_pkg::urd_tri_s eq = '0;
    logic scl = 1'b0;
    logic sda = 1'b0;
    logic sel = 1'b0;
    urd_pkg::urd_line_s ev = '0;
    urd_pkg::urd_line_s line;
    logic [1:0] eb = 2'h0;
    logic [1:0] db = 2'h0;
    logic we = 1'b0;
    logic [6:0] addr = 7'h0;
    logic av = 1'b0;
    logic i2c_mode, amatch, shutdown, ready, chg, ded, dwn;
    logic hs, eq_oe, att, scl_oe;
    urd_pkg::urd_comp_s comp;
    int num_errors = 0;
    int checks_done = 0;
    int n;
    always #12.5 sys_clk = ~sys_clk;
    urd_line_peer peer (.sys_clk(sys_clk), .ev(ev), .line(line));
    urd_ctrl #(.RST_PW_CYCLES(PW), .READY_CYCLES(RDY)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .reset_shutdown_n(pin_n),
        .boost_strap(boost), .rx_equaliser_strap(eq), .scl_in(scl),
        .sda_in(sda), .charge_port_select(sel), .line(line),
        .i2c_edge_boost(eb), .i2c_dc_boost(db), .i2c_boost_we(we),
        .i2c_rx_addr(addr), .i2c_addr_valid(av), .i2c_mode(i2c_mode),
        .i2c_addr_match(amatch), .shutdown(shutdown),
        .device_ready(ready), .charger_en(chg),
        .dedicated_charge_behaviour(ded),
        .downstream_charge_behaviour(dwn), .comp(comp),
        .hs_active_flag(hs), .eq_pin_oe(eq_oe), .attach_flag(att),
        .scl_pin_oe(scl_oe)
    );
    // ----------------
    // helpers
    // ----------------
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask : tick
    task automatic wait_ready();
        n = 0;
        while (ready !== 1'b1 && n < 60) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 60) begin
            num_errors++;
            close_out();
        end
        chk({7'h0, n <= RDY + 3}, 8'h1);
    endtask : wait_ready
    task automatic power_up(input logic [1:0] b, input logic lv,
        input logic fl, input logic c, input logic d);
        tick(1);
        rst_n <= 1'b0;
        pin_n <= 1'b0;
        boost <= b;
        eq <= '{level: lv, floating: fl};
        scl <= c;
        sda <= d;
        tick(3);
        rst_n <= 1'b1;
        tick(PW + 2);
        pin_n <= 1'b1;
        wait_ready();
    endtask : power_up
    task automatic pulse(input urd_pkg::urd_line_s v);
        tick(1);
        ev <= v;
        tick(1);
        ev <= '0;
        tick(2);
        @(negedge sys_clk);
    endtask : pulse
    task automatic addr_try(input logic [6:0] a);
        tick(1);
        addr <= a;
        av <= 1'b1;
        tick(1);
        av <= 1'b0;
        @(negedge sys_clk);
    endtask : addr_try
    task automatic boost_wr(input logic [1:0] e, input logic [1:0] d);
        tick(1);
        eb <= e;
        db <= d;
        we <= 1'b1;
        tick(1);
        we <= 1'b0;
        tick(1);
        @(negedge sys_clk);
    endtask : boost_wr
    // ----------------
    // sequence
    // ----------------
    initial begin
        for (int k = 0; k < 3; k++) begin
            power_up(2'(k), k == 2, k == 1, k == 0, k == 1);
            chk({4'h0, comp.edge_boost, comp.dc_boost}, 8'(k * 5));
            chk({6'h0, comp.eq_level}, {6'h0, EQX[k]});
            chk({5'h0, i2c_mode, eq_oe, scl_oe}, 8'h03);
        end
        $display("test straps done");
        addr_try(7'h2c);
        chk({7'h0, amatch}, 8'h0);
        boost <= 2'h0;
        boost_wr(2'h1, 2'h3);
        chk({4'h0, comp.edge_boost, comp.dc_boost}, 8'h0a);
        for (int k = 0; k < 2; k++) begin
            tick(1);
            sel <= k[0];
            tick(2);
            @(negedge sys_clk);
            chk({5'h0, chg, ded, dwn}, 8'(6 - k));
        end
        $display("test pin mode done");
        peer.fixture();
        pulse('0);
        chk({6'h0, att, hs}, 8'h1);
        pulse(DISC);
        chk({6'h0, att, hs}, 8'h0);
        pulse(PULL);
        chk({6'h0, att, hs}, 8'h2);
        for (int k = 0; k < 3; k++) begin
            peer.chirp(JC[k], KC[k]);
            pulse('0);
            chk({6'h0, att, hs}, 8'(2 + (k == 2)));
        end
        pulse(DISC);
        chk({6'h0, att, hs}, 8'h0);
        tick(1);
        ev <= LS;
        tick(3);
        @(negedge sys_clk);
        chk({5'h0, att, hs, comp.comp_en}, 8'h4);
        ev <= '0;
        pulse(DISC);
        $display("test line events done");
        for (int k = 0; k < 2; k++) begin
            tick(1);
            pin_n <= 1'b0;
            tick(k == 0 ? PW - 4 : PW + 4);
            pin_n <= 1'b1;
            @(negedge sys_clk);
            chk({7'h0, shutdown}, 8'(k));
        end
        wait_ready();
        $display("test reset pin done");
        power_up(2'h3, 1'b0, 1'b1, 1'b1, 1'b1);
        chk({5'h0, i2c_mode, eq_oe, scl_oe}, 8'h04);
        chk({4'h0, comp.edge_boost, comp.dc_boost}, 8'h0f);
        boost_wr(2'h2, 2'h0);
        chk({4'h0, comp.edge_boost, comp.dc_boost}, 8'h08);
        for (int k = 0; k < 2; k++) begin
            addr_try(7'(7'h2c + k));
            chk({7'h0, amatch}, 8'(1 - k));
        end
        $display("test serial mode done");
        close_out();
    end
    initial begin
        tick(60000);
        num_errors++;
        close_out();
    end
endmodule : urd_ctrl_tb
